// ---- hw/scp_consts.vh ----
// Purpose: shared constants of the serial control port, SPI side
// Assumes: included by the port module by bare name
// Notes: offsets are 13-bit register addresses
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH

// register addresses handled inside the port
`define SCP_OFS_PORT_CFG 13'h0000
`define SCP_OFS_RB_SEL 13'h0004
`define SCP_OFS_COMMIT 13'h0005

// field positions
`define SCP_CFG_UNI_BIT 7
`define SCP_CFG_LSB_BIT 6
`define SCP_RB_ACTIVE_BIT 0
`define SCP_COMMIT_BIT 0

// reset values
`define SCP_CFG_UNI_RST 1'b0
`define SCP_CFG_LSB_RST 1'b0
`define SCP_RB_ACTIVE_RST 1'b0

// protocol selection
`define SCP_SPI_PINS 3'h0
`define SCP_I2C_ADDR_HI 4'h9

// instruction word layout
`define SCP_INSTR_RW_BIT 15
`define SCP_INSTR_LEN_HI 14
`define SCP_INSTR_LEN_LO 13
`define SCP_INSTR_ADDR_HI 12
`define SCP_INSTR_LAST 4'hf
`define SCP_BYTE_LAST 3'h7
`define SCP_LEN_STREAM 2'h3

`endif

// ---- hw/scp_spi_port.v ----
// Purpose: SPI slave side of the serial control port, sampled by the core clock
// Assumes: sclk half period of at least three core clocks; register map outside
// Assumes: reg_rdata inputs are valid for reg_addr in the same cycle as reg_rd
// Notes: sclk, cs_n, sdio_i and the straps pass two flip-flops before use
// Notes: addresses 0, 4 and 5 are served here and never reach the register map
// Operation
// - startup select pins all low pick SPI, else I2C address 1001 plus pins
// - chosen protocol stays fixed until a device reset re-samples the pins
// - write bits are taken on sclk rising edges, read bits launched on falling
// - data pin is input only in 4-wire mode; read data then on serial output pin
// - chip select high tri-states both the data pin and the serial output pin
// - reset gives 3-wire, msb-first; software may change wiring and bit order
// - short transfers may stall high on byte boundaries and resume on select low
// - length code 00,01,10 give 1,2,3 bytes; 11 streams without bound
// - host aborts a stall by finishing it or clocking 1 to 7 bits
// - chip select rising off a byte boundary ends transfer, drops partial data
// - streaming steps address every byte; chip select rising ends the stream
// - each cycle opens with a 16-bit instruction on the first 16 rising edges
// - only the 16-bit instruction form is decoded
// - multibyte writes skip no address; every address gets a byte
// - buffered writes act only after an I/O update from bit or pin
// - a read shifts out N times eight bits from the addressed registers
// - readback comes from buffered or active copies, by bit 0 of select register
// - port configuration register lives here, apart from the register map
// - instruction bit 15 is read flag, 14:13 length, 12:0 start address
// - bit 6 of port configuration selects lsb-first instruction and data
// - address decrements in msb-first mode and increments in lsb-first mode
`timescale 1ns/10ps
`include "scp_consts.vh"

module scp_spi_port #(
   parameter ADDR_W = 13
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // serial pins
   input wire sclk,
   input wire cs_n,
   input wire sdio_i,
   output wire sdio_o,
   output wire sdio_oe,
   output wire serial_output_pin,
   output wire serial_output_pin_oe,
   // strap and update pins
   input wire [2:0] protocol_select_pins,
   input wire io_update_pin,
   // protocol outcome
   output wire spi_selected,
   output wire [6:0] i2c_slave_addr,
   // register map side
   output wire [ADDR_W-1:0] reg_addr,
   output wire [7:0] reg_wdata,
   output wire reg_wr,
   output wire reg_rd,
   input wire [7:0] reg_rdata_buffered,
   input wire [7:0] reg_rdata_active,
   output wire io_update
);

   // engine states
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_INSTR = 2'h1;
   localparam [1:0] ST_DATA = 2'h2;
   localparam [1:0] ST_DONE = 2'h3;

   // synchroniser stages: sclk, cs_n, data, update pin, straps
   reg [6:0] s1_q;
   reg [6:0] s2_q;
   reg [6:0] s3_q;

   // protocol capture
   reg cap_done_q;
   reg spi_sel_q;
   reg [6:0] i2c_addr_q;

   // transfer engine
   reg [1:0] st_q;
   reg [3:0] cnt_q;
   reg [15:0] instr_q;
   reg [7:0] rx_q;
   reg [7:0] tx_q;
   reg out_q;
   reg rw_q;
   reg stream_q;
   reg [1:0] left_q;
   reg [ADDR_W-1:0] addr_q;
   reg lsb_act_q;
   reg uni_act_q;
   reg stall_ok;
   reg st_drive;

   // local registers
   reg cfg_uni_q;
   reg cfg_lsb_q;
   reg rb_act_q;

   // register map handshake
   reg [ADDR_W-1:0] reg_addr_q;
   reg [7:0] reg_wdata_q;
   reg reg_wr_q;
   reg reg_rd_q;
   reg fetch_q;
   reg io_update_q;

   // synchronised views and edges
   wire sclk_s = s2_q[6];
   wire cs_s = s2_q[5];
   wire din_s = s2_q[4];
   wire upd_s = s2_q[3];
   wire [2:0] pins_s = s2_q[2:0];
   wire sclk_rise = sclk_s & ~s3_q[6];
   wire sclk_fall = ~sclk_s & s3_q[6];
   wire cs_rise = cs_s & ~s3_q[5];
   wire cs_fall = ~cs_s & s3_q[5];
   wire upd_rise = upd_s & ~s3_q[3];
   wire on_boundary = (cnt_q[2:0] == 3'h0);

   // bit insertion in the active order
   wire [15:0] instr_nx = lsb_act_q ? {din_s, instr_q[15:1]} : {instr_q[14:0], din_s};
   wire [7:0] rx_nx = lsb_act_q ? {din_s, rx_q[7:1]} : {rx_q[6:0], din_s};
   wire [ADDR_W-1:0] addr_step = lsb_act_q ? addr_q + 1'b1 : addr_q - 1'b1;
   // no payload byte left in a bounded transfer
   wire last_byte = ~stream_q & (left_q == 2'h0);

   // cs high: any transfer may wait after its first instruction byte, a bounded one on a data byte boundary; anything else ends
   always @* begin
      case (st_q)
         ST_INSTR: stall_ok = on_boundary & (cnt_q != 4'h0);
         ST_DATA: stall_ok = on_boundary & ~stream_q;
         default: stall_ok = 1'b0;
      endcase
   end

   // states in which a read may hold the data line
   always @* begin
      case (st_q)
         ST_DATA: st_drive = 1'b1;
         ST_DONE: st_drive = 1'b1;
         default: st_drive = 1'b0;
      endcase
   end

   // payload length code of an instruction word
   function [1:0] len_code;
      input [15:0] w;
      begin
         len_code = w[`SCP_INSTR_LEN_HI:`SCP_INSTR_LEN_LO];
      end
   endfunction

   // start address field of an instruction word
   function [ADDR_W-1:0] start_addr;
      input [15:0] w;
      begin
         start_addr = w[`SCP_INSTR_ADDR_HI:0];
      end
   endfunction

   // addresses served inside the port rather than by the register map
   function is_local;
      input [ADDR_W-1:0] a;
      begin
         is_local = (a == `SCP_OFS_PORT_CFG) || (a == `SCP_OFS_RB_SEL) ||
                    (a == `SCP_OFS_COMMIT);
      end
   endfunction

   // readback of the local registers; reserved bits read zero
   function [7:0] local_rd;
      input [ADDR_W-1:0] a;
      input uni;
      input lsb;
      input rb;
      begin
         local_rd = 8'h00;
         if (a == `SCP_OFS_PORT_CFG) begin
            local_rd[`SCP_CFG_UNI_BIT] = uni;
            local_rd[`SCP_CFG_LSB_BIT] = lsb;
         end else if (a == `SCP_OFS_RB_SEL) begin
            local_rd[`SCP_RB_ACTIVE_BIT] = rb;
         end
      end
   endfunction

   // two-stage synchronisers plus an edge stage; data, no reset needed
   always @(posedge clk) begin
      s1_q <= {sclk, cs_n, sdio_i, io_update_pin, protocol_select_pins};
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   // straps caught once at the first edge after reset release
   always @(posedge clk) begin
      if (rst) begin
         cap_done_q <= 1'b0;
         spi_sel_q <= 1'b0;
         i2c_addr_q <= 7'h00;
      end else if (!cap_done_q) begin
         cap_done_q <= 1'b1;
         spi_sel_q <= (pins_s == `SCP_SPI_PINS);
         i2c_addr_q <= {`SCP_I2C_ADDR_HI, pins_s};
      end
   end

   // transfer engine and local registers
   always @(posedge clk) begin
      if (rst) begin
         // engine idle, nothing half received
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         instr_q <= 16'h0000;
         rx_q <= 8'h00;
         tx_q <= 8'h00;
         out_q <= 1'b0;
         rw_q <= 1'b0;
         stream_q <= 1'b0;
         left_q <= 2'h0;
         addr_q <= {ADDR_W{1'b0}};
         // wiring and bit order back to 3-wire, msb first
         lsb_act_q <= `SCP_CFG_LSB_RST;
         uni_act_q <= `SCP_CFG_UNI_RST;
         cfg_uni_q <= `SCP_CFG_UNI_RST;
         cfg_lsb_q <= `SCP_CFG_LSB_RST;
         rb_act_q <= `SCP_RB_ACTIVE_RST;
         // register map side quiet
         reg_addr_q <= {ADDR_W{1'b0}};
         reg_wdata_q <= 8'h00;
         reg_wr_q <= 1'b0;
         reg_rd_q <= 1'b0;
         fetch_q <= 1'b0;
         io_update_q <= 1'b0;
      end else begin
         // strobes last one cycle; the update pin edge becomes a pulse
         reg_wr_q <= 1'b0;
         reg_rd_q <= 1'b0;
         fetch_q <= 1'b0;
         io_update_q <= upd_rise;
         if (!spi_sel_q) begin
            st_q <= ST_IDLE;
         end else if (cs_rise) begin
            // stall only after the first instruction byte, or on a data byte boundary of a bounded transfer
            if (!stall_ok) begin
               st_q <= ST_IDLE;
               cnt_q <= 4'h0;
               rx_q <= 8'h00;
            end
         end else if (cs_fall && st_q == ST_IDLE) begin
            // a new transfer picks up the latest port configuration
            st_q <= ST_INSTR;
            cnt_q <= 4'h0;
            lsb_act_q <= cfg_lsb_q;
            uni_act_q <= cfg_uni_q;
         end else if (!cs_s && sclk_rise && st_q == ST_INSTR) begin
            instr_q <= instr_nx;
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `SCP_INSTR_LAST) begin
               // full 16-bit word only; no short form exists
               st_q <= ST_DATA;
               cnt_q <= 4'h0;
               // decode direction, length and start address
               rw_q <= instr_nx[`SCP_INSTR_RW_BIT];
               stream_q <= (len_code(instr_nx) == `SCP_LEN_STREAM);
               left_q <= len_code(instr_nx);
               addr_q <= start_addr(instr_nx);
               if (instr_nx[`SCP_INSTR_RW_BIT]) begin
                  // first read byte is fetched now, ahead of the first falling edge
                  reg_addr_q <= start_addr(instr_nx);
                  reg_rd_q <= ~is_local(start_addr(instr_nx));
                  fetch_q <= 1'b1;
               end
            end
         end else if (!cs_s && sclk_rise && st_q == ST_DATA) begin
            rx_q <= rx_nx;
            cnt_q <= {1'b0, cnt_q[2:0] + 3'h1};
            if (cnt_q[2:0] == `SCP_BYTE_LAST) begin
               addr_q <= addr_step;
               if (!stream_q) begin
                  left_q <= left_q - 2'h1;
               end
               if (last_byte) begin
                  st_q <= ST_DONE;
               end
               if (!rw_q) begin
                  // completed byte goes to its address, reserved or not
                  reg_addr_q <= addr_q;
                  reg_wdata_q <= rx_nx;
                  if (addr_q == `SCP_OFS_PORT_CFG) begin
                     cfg_uni_q <= rx_nx[`SCP_CFG_UNI_BIT];
                     cfg_lsb_q <= rx_nx[`SCP_CFG_LSB_BIT];
                  end else if (addr_q == `SCP_OFS_RB_SEL) begin
                     rb_act_q <= rx_nx[`SCP_RB_ACTIVE_BIT];
                  end else if (addr_q == `SCP_OFS_COMMIT) begin
                     // self-clearing: only the pulse is kept
                     io_update_q <= rx_nx[`SCP_COMMIT_BIT] | upd_rise;
                  end else begin
                     reg_wr_q <= 1'b1;
                  end
               end else if (!last_byte) begin
                  // next read byte, address stepped in the active order
                  reg_addr_q <= addr_step;
                  reg_rd_q <= ~is_local(addr_step);
                  fetch_q <= 1'b1;
               end
            end
         end
         // read bits leave on falling edges, first after the instruction
         if (spi_sel_q && !cs_s && sclk_fall && st_q == ST_DATA && rw_q) begin
            out_q <= lsb_act_q ? tx_q[0] : tx_q[7];
            tx_q <= lsb_act_q ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
         end
         // byte fetched one cycle after the address was presented
         if (fetch_q) begin
            if (is_local(reg_addr_q)) begin
               tx_q <= local_rd(reg_addr_q, cfg_uni_q, cfg_lsb_q, rb_act_q);
            end else begin
               tx_q <= rb_act_q ? reg_rdata_active : reg_rdata_buffered;
            end
         end
      end
   end

   // read driver: after the instruction, released once select goes high
   wire drive_rd = spi_sel_q & ~cs_s & rw_q & st_drive;
   assign sdio_oe = drive_rd & ~uni_act_q;
   assign serial_output_pin_oe = drive_rd & uni_act_q;
   // one output register feeds both data pins; the enables pick the pin
   assign sdio_o = out_q;
   assign serial_output_pin = out_q;

   // outcome and register map outputs
   assign spi_selected = spi_sel_q;
   assign i2c_slave_addr = i2c_addr_q;
   assign reg_addr = reg_addr_q;
   assign reg_wdata = reg_wdata_q;
   assign reg_wr = reg_wr_q;
   assign reg_rd = reg_rd_q;
   assign io_update = io_update_q;

endmodule

// ---- bench/scp_spi_checker.sv ----
// Purpose: port checks of the SPI serial control port
// Assumes: one clock domain, synchronous reset
// Notes: bound onto the port from the bench top
`timescale 1ns/10ps
module scp_spi_checker (
   // clock and reset
   input wire clk,
   input wire rst,
   // serial pins
   input wire sclk,
   input wire cs_n,
   input wire sdio_o,
   input wire sdio_oe,
   input wire serial_output_pin_oe,
   // outcomes
   input wire spi_selected,
   input wire [6:0] i2c_slave_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire io_update
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // drivers released once select has settled high
   AST_CS_TRISTATE: assert property (cs_n [*4] |-> !sdio_oe && !serial_output_pin_oe)
      else $error("driver on while deselected");
   AST_ONE_DRIVER: assert property (!(sdio_oe && serial_output_pin_oe))
      else $error("both data outputs driven");
   AST_WR_PULSE: assert property (reg_wr |=> !reg_wr ##1 !reg_wr)
      else $error("write strobe too long");
   AST_RD_PULSE: assert property (reg_rd |=> !reg_rd)
      else $error("read strobe too long");
   AST_UPD_PULSE: assert property (io_update |=> !io_update)
      else $error("update strobe too long");
   // protocol choice only moves on the capture edge after reset
   AST_PROTO_FIXED: assert property (!$past(rst) && !$past(rst, 2) |-> $stable(spi_selected))
      else $error("protocol changed without reset");
   AST_STRAP_ADDR: assert property (!$past(rst) |->
      i2c_slave_addr[6:3] == 4'h9 && spi_selected == (i2c_slave_addr[2:0] == 3'h0))
      else $error("strap decode wrong");
   AST_I2C_QUIET: assert property (!spi_selected && !$past(rst) |-> !reg_wr && !sdio_oe)
      else $error("SPI active while not selected");
   AST_WR_CAUSE: assert property (reg_wr |-> !$past(cs_n, 3))
      else $error("write without a selected transfer");
   AST_OE_START: assert property ($rose(sdio_oe || serial_output_pin_oe) |->
      (sclk && !$past(cs_n, 3)) || (!sclk && $past(cs_n, 3)))
      else $error("read driver enabled off an instruction edge");
   AST_LAUNCH_FALL: assert property ($past(sdio_oe, 2) && $changed(sdio_o) |-> !sclk)
      else $error("read bit launched while clock high");
   // main scenarios reached
   cover property (reg_wr);
   cover property ($rose(sdio_oe));
   cover property ($rose(serial_output_pin_oe));
   cover property (io_update);
endmodule

// ---- bench/scp_host_model.sv ----
// Purpose: SPI master standing for the host processor
// Assumes: mode 0, 160 ns per bit, clock still outside frames
// Notes: a released data line shows a toggling pattern
`timescale 1ns/10ps
module scp_host_model (
   // serial pins
   output logic sclk,
   output logic cs_n,
   output wire sdio_i,
   input wire sdio_o,
   input wire sdio_oe,
   input wire serial_output_pin,
   input wire serial_output_pin_oe
);
   logic dq = 1'b0, drv = 1'b1, lsb = 1'b0, uni = 1'b0;
   logic [7:0] txq[$], rxq[$];
   wire rx_bit;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
   end
   // shared data wire resolves device and host drivers
   assign sdio_i = sdio_oe ? sdio_o : dq;
   assign rx_bit = uni ? (serial_output_pin_oe ? serial_output_pin : dq) : sdio_i;
   // one byte, write bit set before the rise, read bit taken at it
   task automatic byte8(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 0; i < 8; i++) begin
         dq = drv ? tx[lsb ? i : 7 - i] : ~dq;
         #80 sclk = 1'b1;
         rx[lsb ? i : 7 - i] = rx_bit;
         #80 sclk = 1'b0;
      end
   endtask
   // whole transfer, optional stall before each payload byte
   task automatic xfer(input logic [15:0] ins, input int n, input bit stall);
      logic [7:0] r;
      cs_n = 1'b0;
      #80;
      byte8(lsb ? ins[7:0] : ins[15:8], r);
      byte8(lsb ? ins[15:8] : ins[7:0], r);
      drv = !ins[15];
      for (int k = 0; k < n; k++) begin
         if (stall) begin
            cs_n = 1'b1;
            #400 cs_n = 1'b0;
            #80;
         end
         byte8(ins[15] ? 8'h00 : txq.pop_front(), r);
         if (ins[15]) rxq.push_back(r);
      end
      #80 cs_n = 1'b1;
      drv = 1'b1;
      #400;
   endtask
   // abort by a few bits then deselect
   task automatic cut(input int nb);
      cs_n = 1'b0;
      #80;
      repeat (nb) begin
         #80 sclk = 1'b1;
         #80 sclk = 1'b0;
      end
      #80 cs_n = 1'b1;
      #400;
   endtask
endmodule

// ---- bench/serial_control_port_spi_test.sv ----
// Purpose: self-checking bench of the SPI serial control port
// Assumes: register map read data derived from the address
// Notes: write strobes are checked against a queue of notes
`timescale 1ns/10ps
module serial_control_port_spi_test;
   logic clk = 1'b0, rst = 1'b1, upd_pin = 1'b0;
   logic [2:0] pins = 3'h5;
   logic [20:0] exp_q[$];
   int error_cnt = 0, cmp_count = 0, upd_cnt = 0, rd_cnt = 0;
   wire sclk, cs_n, sdio_i, sdio_o, sdio_oe, so, so_oe, spi_sel, wr_s, rd_s, upd;
   wire [6:0] i2c_addr;
   wire [12:0] reg_addr;
   wire [7:0] wdata, rb_buf, rb_act;
   always #2.5 clk = ~clk;
   // register map stand-in
   function automatic [7:0] mem(input [12:0] a, input bit act);
      mem = a[7:0] ^ (act ? 8'ha5 : 8'h5a);
   endfunction
   assign rb_buf = mem(reg_addr, 1'b0);
   assign rb_act = mem(reg_addr, 1'b1);
   scp_spi_port dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i),
      .sdio_o(sdio_o), .sdio_oe(sdio_oe), .serial_output_pin(so), .serial_output_pin_oe(so_oe),
      .protocol_select_pins(pins), .io_update_pin(upd_pin), .spi_selected(spi_sel),
      .i2c_slave_addr(i2c_addr), .reg_addr(reg_addr), .reg_wdata(wdata), .reg_wr(wr_s),
      .reg_rd(rd_s), .reg_rdata_buffered(rb_buf), .reg_rdata_active(rb_act), .io_update(upd));
   scp_host_model h (.sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o),
      .sdio_oe(sdio_oe), .serial_output_pin(so), .serial_output_pin_oe(so_oe));
   task check(input logic [20:0] seen, input logic [20:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // write n bytes, noting each expected map strobe only when the data is random (v below zero)
   task automatic wr(input [12:0] a, input [1:0] len, input int n, input bit st, input int v);
      logic [7:0] d;
      for (int k = 0; k < n; k++) begin
         d = (v < 0) ? 8'($urandom) : 8'(v);
         h.txq.push_back(d);
         if (v < 0) exp_q.push_back({13'(h.lsb ? a + k : a - k), d});
      end
      h.xfer({1'b0, len, a}, n, st);
   endtask
   task automatic rd(input [12:0] a, input [1:0] len, input int n, input bit act);
      h.xfer({1'b1, len, a}, n, 1'b0);
      for (int k = 0; k < n; k++)
         check(h.rxq.pop_front(), mem(13'(h.lsb ? a + k : a - k), act));
   endtask
   // watcher takes the oldest note per write strobe
   always @(negedge clk) begin
      if (wr_s === 1'b1) check({reg_addr, wdata}, exp_q.size() ? exp_q.pop_front() : '1);
      if (upd === 1'b1) upd_cnt++;
      if (rd_s === 1'b1) rd_cnt++;
   end
   initial begin
      for (int i = 0; i < 90000; i++) @(posedge clk);
      error_cnt++;
      finish_test;
   end
   initial begin
      void'($urandom(32'h82c42b59));
      tick(4);
      rst = 1'b0;
      tick(3);
      check(spi_sel, 1'b0);
      check(i2c_addr, 7'h4d);
      pins = 3'h0;
      tick(8);
      check(spi_sel, 1'b0);
      rst = 1'b1;
      tick(4);
      rst = 1'b0;
      tick(10);
      check(spi_sel, 1'b1);
      wr(13'h0123, 2'h2, 3, 1'b1, -1);
      h.cut(5);
      wr(13'h0a00, 2'h3, 4, 1'b0, -1);
      wr(13'h0005, 2'h0, 1, 1'b0, 1);
      upd_pin = 1'b1;
      tick(8);
      upd_pin = 1'b0;
      tick(8);
      rd(13'h0100, 2'h1, 2, 1'b0);
      wr(13'h0004, 2'h0, 1, 1'b0, 1);
      rd(13'h0042, 2'h0, 1, 1'b1);
      wr(13'h0000, 2'h0, 1, 1'b0, 8'hc0);
      h.lsb = 1'b1;
      h.uni = 1'b1;
      wr(13'h0200, 2'h1, 2, 1'b0, -1);
      rd(13'h0300, 2'h1, 2, 1'b1);
      h.xfer({1'b1, 2'h0, 13'h0000}, 1, 1'b0);
      check(h.rxq.pop_front(), 8'hc0);
      tick(20);
      check(exp_q.size(), 0);
      check(upd_cnt, 2);
      check(rd_cnt, 5);
      finish_test;
   end
endmodule
bind scp_spi_port scp_spi_checker chk (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
   .sdio_o(sdio_o), .sdio_oe(sdio_oe), .serial_output_pin_oe(serial_output_pin_oe),
   .spi_selected(spi_selected), .i2c_slave_addr(i2c_slave_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .io_update(io_update));
